// File: core/pram_fifo_engine.sv
/*
  Process RAM FIFO transfer engine: moves process data between the
  process RAM and the local host through a read FIFO and a write FIFO.
  Assumes host strobes are synchronous one-cycle pulses on mclk_i and
  that the process RAM answers a read one cycle after pram_o.rd.
*/
module pram_fifo_engine (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    fifo_direct_i,
  input  wire pram_fifo_pkg::host_req_t host_i,
  output logic [31:0]                  host_rdata_o,
  output pram_fifo_pkg::pram_req_t     pram_o,
  input  wire logic [31:0]             pram_rdata_i
);

  pram_fifo_pkg::state_t s;
  pram_fifo_pkg::state_t next_s;

  // Valid lanes of the word at byte pointer lo with len bytes left;
  // one formula covers first, middle, last and single-word cases
  function automatic logic [3:0] lanes(input logic [1:0] lo,
                                       input logic [15:0] len);
    logic [15:0] room;
    logic [15:0] hi;
    lanes = 4'h0;
    room  = 16'h0004 - {14'h0000, lo};
    hi    = (len >= room) ? 16'h0003 : {14'h0000, lo} + len - 16'h0001;
    for (int i = 0; i < 4; i++) begin
      if (i >= int'(lo) && i <= int'(hi)) begin
        lanes[i] = 1'b1;
      end
    end
  endfunction

  // Bytes of the transfer held in the word at byte pointer lo
  function automatic logic [15:0] taken(input logic [1:0] lo,
                                        input logic [15:0] len);
    logic [15:0] room;
    room  = 16'h0004 - {14'h0000, lo};
    taken = (len < room) ? len : room;
  endfunction

  // Status word of a command register
  function automatic logic [31:0] cmd_word(input logic busy,
                                           input logic flag,
                                           input logic [4:0] cnt);
    cmd_word = 32'h0000_0000;
    cmd_word[pram_fifo_pkg::CMD_BUSY_BIT] = busy;
    cmd_word[pram_fifo_pkg::CMD_FLAG_BIT] = flag;
    cmd_word[pram_fifo_pkg::CMD_CNT_LSB +: 5] = cnt;
  endfunction

  logic        rd_port_hit;
  logic        wr_port_hit;
  logic        reg_ok;
  logic        rd_pop;
  logic        rd_push;
  logic        wr_push;
  logic        wr_drain;
  logic        wr_go;
  logic [4:0]  wr_free;
  logic [15:0] step;
  logic [31:0] reg_rdata;

  // Address decode; aliases only compare the upper address bits
  always_comb begin
    reg_ok      = !fifo_direct_i;
    rd_port_hit = host_i.rd && (fifo_direct_i ||
                  (host_i.addr & pram_fifo_pkg::PORT_MASK) ==
                  pram_fifo_pkg::RD_PORT_OFS);
    wr_port_hit = host_i.wr && (fifo_direct_i ||
                  (host_i.addr & pram_fifo_pkg::PORT_MASK) ==
                  pram_fifo_pkg::WR_PORT_OFS);
    wr_free     = pram_fifo_pkg::FIFO_FULL_CNT - s.wf.count;
    // The RAM port carries one access a cycle; a draining write wins
    wr_go       = s.wr.busy && s.wr.len != 16'h0000 &&
                  s.wf.count != 5'h00;
  end

  // Register read mux; unmapped offsets and cancel bits read as zero
  always_comb begin
    reg_rdata = pram_fifo_pkg::DATA_RESET;
    if (reg_ok) begin
      case (host_i.addr)
        pram_fifo_pkg::RD_SPAN_OFS: reg_rdata = {s.rd.len, s.rd.ptr};
        pram_fifo_pkg::WR_SPAN_OFS: reg_rdata = {s.wr.len, s.wr.ptr};
        pram_fifo_pkg::RD_CMD_OFS:
          reg_rdata = cmd_word(s.rd.busy, s.rf.count != 5'h00,
                               s.rf.count);
        pram_fifo_pkg::WR_CMD_OFS:
          reg_rdata = cmd_word(s.wr.busy, wr_free != 5'h00,
                               wr_free);
        default: reg_rdata = pram_fifo_pkg::DATA_RESET;
      endcase
    end
  end

  // Next state of the whole engine
  always_comb begin
    next_s       = s;
    next_s.pram  = '0;
    next_s.rtn   = s.pram.rd;
    step         = 16'h0000;
    rd_pop       = 1'b0;
    rd_push      = 1'b0;
    wr_push      = 1'b0;
    wr_drain     = 1'b0;
    next_s.rdata = host_i.rd ? reg_rdata : s.rdata;

    // Host pops the read FIFO; every alias pops one whole word.
    // An empty pop returns zero and moves nothing.
    if (rd_port_hit) begin
      next_s.rdata = pram_fifo_pkg::DATA_RESET;
      if (s.rf.count != 5'h00) begin
        rd_pop       = 1'b1;
        next_s.rdata = s.rf.mem[s.rf.head];
        next_s.rf.head = s.rf.head + 4'h1;
      end
    end

    // RAM read data returns one cycle after the request; a cancelled
    // request has pend cleared, so its late data is dropped
    if (s.rtn && s.rd.pend) begin
      rd_push             = 1'b1;
      next_s.rd.pend      = 1'b0;
      next_s.rf.mem[s.rf.tail] = pram_rdata_i;
      next_s.rf.tail      = s.rf.tail + 4'h1;
    end
    next_s.rf.count = s.rf.count + {4'h0, rd_push} - {4'h0, rd_pop};

    // Read engine issues one word at a time, leaving room in the FIFO
    // for the word still in flight
    // for the word still in flight; it yields the port to a write
    if (s.rd.busy && s.rd.len != 16'h0000 && !s.rd.pend && !wr_go &&
        s.rf.count < pram_fifo_pkg::FIFO_FULL_CNT) begin
      step             = taken(s.rd.ptr[1:0], s.rd.len);
      next_s.pram.rd   = 1'b1;
      next_s.pram.waddr = s.rd.ptr[15:2];
      next_s.pram.be   = lanes(s.rd.ptr[1:0], s.rd.len);
      next_s.rd.pend   = 1'b1;
      next_s.rd.ptr    = {s.rd.ptr[15:2] + 14'h0001, 2'b00};
      next_s.rd.len    = s.rd.len - step;
    end

    // Busy drops on the pop that takes the last word of the transfer
    if (s.rd.busy && s.rd.len == 16'h0000 && !s.rd.pend &&
        rd_pop && s.rf.count == 5'h01) begin
      next_s.rd.busy = 1'b0;
    end

    // Host pushes the write FIFO; a push into a full FIFO is dropped
    if (wr_port_hit && s.wf.count < pram_fifo_pkg::FIFO_FULL_CNT) begin
      wr_push = 1'b1;
      next_s.wf.mem[s.wf.tail] = host_i.wdata;
      next_s.wf.tail = s.wf.tail + 4'h1;
    end

    // Write engine drains one word per cycle, storing only valid lanes
    if (wr_go) begin
      wr_drain           = 1'b1;
      step               = taken(s.wr.ptr[1:0], s.wr.len);
      next_s.pram.wr     = 1'b1;
      next_s.pram.waddr  = s.wr.ptr[15:2];
      next_s.pram.be     = lanes(s.wr.ptr[1:0], s.wr.len);
      next_s.pram.wdata  = s.wf.mem[s.wf.head];
      next_s.wf.head     = s.wf.head + 4'h1;
      next_s.wr.ptr      = {s.wr.ptr[15:2] + 14'h0001, 2'b00};
      next_s.wr.len      = s.wr.len - step;
      if (s.wr.len == step) begin
        next_s.wr.busy = 1'b0;
      end
    end
    next_s.wf.count = s.wf.count + {4'h0, wr_push} - {4'h0, wr_drain};

    // Register writes; they take effect after the engine step above
    if (host_i.wr && reg_ok) begin
      case (host_i.addr)
        pram_fifo_pkg::RD_SPAN_OFS: begin
          next_s.rd.ptr = host_i.wdata[pram_fifo_pkg::SPAN_PTR_LSB +: 16];
          next_s.rd.len = host_i.wdata[pram_fifo_pkg::SPAN_LEN_LSB +: 16];
        end
        pram_fifo_pkg::WR_SPAN_OFS: begin
          next_s.wr.ptr = host_i.wdata[pram_fifo_pkg::SPAN_PTR_LSB +: 16];
          next_s.wr.len = host_i.wdata[pram_fifo_pkg::SPAN_LEN_LSB +: 16];
        end
        pram_fifo_pkg::RD_CMD_OFS: begin
          // Cancel outranks start; both flush stale words
          if (host_i.wdata[pram_fifo_pkg::CMD_CANCEL_BIT]) begin
            next_s.rd.busy = 1'b0;
            next_s.rd.pend = 1'b0;
            next_s.rf      = '0;
            next_s.pram.rd = 1'b0;
          end else if (host_i.wdata[pram_fifo_pkg::CMD_BUSY_BIT] &&
                       !s.rd.busy && s.rd.len != 16'h0000) begin
            next_s.rd.busy = 1'b1;
            next_s.rf      = '0;
          end
        end
        pram_fifo_pkg::WR_CMD_OFS: begin
          if (host_i.wdata[pram_fifo_pkg::CMD_CANCEL_BIT]) begin
            next_s.wr.busy = 1'b0;
            next_s.wf      = '0;
            next_s.pram.wr = 1'b0;
          end else if (host_i.wdata[pram_fifo_pkg::CMD_BUSY_BIT] &&
                       !s.wr.busy && s.wr.len != 16'h0000) begin
            next_s.wr.busy = 1'b1;
            next_s.wf      = '0;
          end
        end
        default: begin
        end
      endcase
    end

    // A cancelled read may not leave a stray request on the RAM port
    if (!next_s.pram.rd && !next_s.pram.wr) begin
      next_s.pram.be    = 4'h0;
      next_s.pram.waddr = 14'h0000;
      next_s.pram.wdata = pram_fifo_pkg::DATA_RESET;
    end
  end

  // Single state register; the FIFO arrays live inside it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flip-flops
  assign host_rdata_o = s.rdata;
  assign pram_o       = s.pram;

endmodule

// File: core/pram_fifo_pkg.sv
/*
  Constants, field layouts and carrier structs for the process RAM
  FIFO transfer engine.
  Assumes a host bus with a 12-bit byte address and one-cycle strobes,
  and a process RAM port that returns read data one cycle after a read.
*/
package pram_fifo_pkg;

  // Geometry
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W      = 4;
  localparam int unsigned CNT_W      = 5;
  localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 5'h10;

  // Host bus register map, byte offsets
  localparam logic [11:0] RD_PORT_OFS  = 12'h000;
  localparam logic [11:0] WR_PORT_OFS  = 12'h020;
  localparam logic [11:0] PORT_MASK    = 12'hfe0;
  localparam logic [11:0] RD_SPAN_OFS  = 12'h308;
  localparam logic [11:0] RD_CMD_OFS   = 12'h30c;
  localparam logic [11:0] WR_SPAN_OFS  = 12'h310;
  localparam logic [11:0] WR_CMD_OFS   = 12'h314;

  // Span register fields: byte pointer low, byte count high
  localparam int unsigned SPAN_PTR_LSB = 0;
  localparam int unsigned SPAN_LEN_LSB = 16;

  // Command register fields
  localparam int unsigned CMD_BUSY_BIT   = 31;
  localparam int unsigned CMD_CANCEL_BIT = 30;
  localparam int unsigned CMD_FLAG_BIT   = 0;
  localparam int unsigned CMD_CNT_LSB    = 8;

  // Reset values
  localparam logic [15:0] PTR_RESET  = 16'h0000;
  localparam logic [15:0] LEN_RESET  = 16'h0000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;

  // One transfer direction: span register plus progress state
  typedef struct packed {
    logic        busy;
    logic        pend;
    logic [15:0] ptr;
    logic [15:0] len;
  } xfer_t;

  // One 16 x 32 FIFO
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
    logic [PTR_W-1:0]                  head;
    logic [PTR_W-1:0]                  tail;
    logic [CNT_W-1:0]                  count;
  } fifo_t;

  // Host bus request
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [11:0]       addr;
    logic [DATA_W-1:0] wdata;
  } host_req_t;

  // Process RAM request, word granular with byte enables
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [13:0]       waddr;
    logic [3:0]        be;
    logic [DATA_W-1:0] wdata;
  } pram_req_t;

  // Whole state of the engine
  typedef struct packed {
    xfer_t             rd;
    xfer_t             wr;
    fifo_t             rf;
    fifo_t             wf;
    pram_req_t         pram;
    logic              rtn;
    logic [DATA_W-1:0] rdata;
  } state_t;

endpackage

// File: testbench/pram_fifo_engine_tb.sv
/* Self-checking bench for the process RAM FIFO engine.
   Assumes package, engine, RAM model and checker compiled first. */
module pram_fifo_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     mclk_i        = 1'b0;
  logic                     rst_n_i       = 1'b0;
  logic                     fifo_direct_i = 1'b0;
  pram_fifo_pkg::host_req_t host_i        = '0;
  logic [31:0]              host_rdata_o;
  pram_fifo_pkg::pram_req_t pram_o;
  logic [31:0]              pram_rdata_i;
  logic [31:0]              d;
  int                       miscompares   = 0;
  int                       n_compared    = 0;
  // 40 MHz clock
  always #12.5 mclk_i = ~mclk_i;
  pram_fifo_engine u_pram_fifo_engine (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .fifo_direct_i(fifo_direct_i),
    .host_i(host_i),
    .host_rdata_o(host_rdata_o),
    .pram_o(pram_o),
    .pram_rdata_i(pram_rdata_i)
  );
  pram_model u_pram_model (
    .mclk_i(mclk_i),
    .req_i(pram_o),
    .rdata_o(pram_rdata_i)
  );
  task automatic results();
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One-cycle strobes, launched just after an edge
  task automatic hwr(input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    host_i <= '{1'b0, 1'b1, a, v};
    @(posedge mclk_i);
    host_i <= '0;
  endtask
  task automatic hrd(input logic [11:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    host_i <= '{1'b1, 1'b0, a, 32'h0};
    @(posedge mclk_i);
    host_i <= '0;
    #1 v = host_rdata_o;
  endtask
  // Bounded status poll; giving up ends the run
  task automatic poll(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] v);
    logic [31:0] r;
    for (int i = 0; i < 40; i++) begin
      hrd(a, r);
      if ((r & m) === v)
        return;
    end
    chk(r & m, v);
    results();
  endtask
  task automatic wr_five();
    hwr(12'h310, 32'h0005_1001);
    hwr(12'h314, 32'h8000_0000);
    hrd(12'h314, d);
    chk(d, 32'h8000_1001);
    hwr(12'h020, 32'h4433_2211);
    hwr(12'h03c, 32'h8877_6655);
    poll(12'h314, 32'h8000_0000, 32'h0);
    chk(u_pram_model.mem[1024], 32'h4433_2200);
    chk(u_pram_model.mem[1025], 32'h0000_6655);
    hrd(12'h310, d);
    chk(d & 32'hffff_0000, 32'h0);
  endtask
  task automatic rd_eight();
    hwr(12'h308, 32'h0008_1000);
    hwr(12'h30c, 32'h8000_0000);
    poll(12'h30c, 32'h0000_1f01, 32'h0000_0201);
    hrd(12'h01c, d);
    chk(d, 32'h4433_2200);
    hrd(12'h004, d);
    chk(d, 32'h0000_6655);
    hrd(12'h30c, d);
    chk(d, 32'h0);
    hrd(12'h308, d);
    chk(d & 32'hffff_0000, 32'h0);
  endtask
  // Single byte in lane 3, data moved with the address ignored
  task automatic direct_one();
    hwr(12'h310, 32'h0001_1013);
    hwr(12'h314, 32'h8000_0000);
    fifo_direct_i <= 1'b1;
    hwr(12'h314, 32'hddcc_bbaa);
    fifo_direct_i <= 1'b0;
    poll(12'h314, 32'h8000_0000, 32'h0);
    chk(u_pram_model.mem[1028], 32'hdd00_0000);
    hwr(12'h308, 32'h0001_1013);
    hwr(12'h30c, 32'h8000_0000);
    poll(12'h30c, 32'h0000_0001, 32'h1);
    fifo_direct_i <= 1'b1;
    hrd(12'h314, d);
    fifo_direct_i <= 1'b0;
    chk(d, 32'hdd00_0000);
  endtask
  task automatic cancel_both();
    hwr(12'h308, 32'h0040_1000);
    hwr(12'h30c, 32'h8000_0000);
    hwr(12'h30c, 32'h4000_0000);
    hrd(12'h30c, d);
    chk(d, 32'h0);
    // Late RAM data of the cancelled read must not refill the FIFO
    hrd(12'h30c, d);
    chk(d, 32'h0);
    hwr(12'h310, 32'h0010_1020);
    hwr(12'h314, 32'h8000_0000);
    hwr(12'h034, 32'h1234_5678);
    hwr(12'h314, 32'h4000_0000);
    hrd(12'h314, d);
    chk(d, 32'h0000_1001);
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    wr_five();
    rd_eight();
    direct_one();
    cancel_both();
    results();
  end
endmodule
bind pram_fifo_engine pram_fifo_monitor u_pram_fifo_monitor (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .fifo_direct_i(fifo_direct_i),
  .host_i(host_i),
  .host_rdata_o(host_rdata_o),
  .pram_o(pram_o),
  .pram_rdata_i(pram_rdata_i)
);

// File: testbench/pram_fifo_monitor.sv
/* Port checker for the process RAM FIFO engine.
   Assumes one clock domain and an active-low asynchronous reset. */
module pram_fifo_monitor (
  input wire logic                     mclk_i,
  input wire logic                     rst_n_i,
  input wire logic                     fifo_direct_i,
  input wire pram_fifo_pkg::host_req_t host_i,
  input wire logic [31:0]              host_rdata_o,
  input wire pram_fifo_pkg::pram_req_t pram_o,
  input wire logic [31:0]              pram_rdata_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic rd_cxl;
  logic wr_cxl;
  logic lanes_ok;
  // Cancel strokes reach the command words only outside direct mode
  assign rd_cxl = host_i.wr && !fifo_direct_i && host_i.wdata[30] &&
                  host_i.addr == 12'h30c;
  assign wr_cxl = host_i.wr && !fifo_direct_i && host_i.wdata[30] &&
                  host_i.addr == 12'h314;
  // Valid lanes always form one unbroken run
  assign lanes_ok = pram_o.be inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6,
                                      4'h7, 4'h8, 4'hc, 4'he, 4'hf};
  rd_gap_a: assert property (pram_o.rd |=> !pram_o.rd)
    else $error("read requests back to back");
  one_dir_a: assert property (!(pram_o.rd && pram_o.wr))
    else $error("read and write together");
  rd_lanes_a: assert property (pram_o.rd |-> lanes_ok)
    else $error("read lanes broken");
  wr_lanes_a: assert property (pram_o.wr |-> lanes_ok)
    else $error("write lanes broken");
  ram_range_a: assert property ((pram_o.rd || pram_o.wr) |->
    pram_o.waddr inside {[14'h0400:14'h07ff]})
    else $error("request outside process RAM");
  data_hold_a: assert property ($changed(host_rdata_o) |->
    $past(host_i.rd))
    else $error("read data changed without a read");
  wr_cause_a: assert property (pram_o.wr |-> $past(host_i.wr) ||
    $past(host_i.wr, 2) || $past(host_i.wr, 3))
    else $error("RAM write without a push");
  rd_stop_a: assert property (rd_cxl |=> !pram_o.rd [*2])
    else $error("RAM read after cancel");
  wr_stop_a: assert property (wr_cxl |=> !pram_o.wr [*2])
    else $error("RAM write after cancel");
endmodule

// File: testbench/pram_model.sv
/* Process RAM model facing the engine.
   Assumes word requests with lanes; read data is due one cycle later. */
module pram_model (
  input  wire logic                     mclk_i,
  input  wire pram_fifo_pkg::pram_req_t req_i,
  output logic [31:0]                   rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:2047];
  initial begin
    rdata_o = 32'h0;
    for (int i = 0; i < 2048; i++)
      mem[i] = 32'h0;
  end
  // Data stands one cycle only; inverted after so stale use shows up
  always @(posedge mclk_i) begin
    if (req_i.rd)
      rdata_o <= mem[req_i.waddr[10:0]];
    else
      rdata_o <= ~rdata_o;
    for (int b = 0; b < 4; b++)
      if (req_i.wr && req_i.be[b])
        mem[req_i.waddr[10:0]][b*8+:8] <= req_i.wdata[b*8+:8];
  end
endmodule
